// >>> jtid_defines.svh
// Constants for the scan test port and its controller
`ifndef JTID_DEFINES_SVH
`define JTID_DEFINES_SVH
`define JTID_IR_W 4
`define JTID_IR_IDCODE 4'h1
`define JTID_IR_BYPASS 4'hf
`define JTID_IR_CAPTURE 4'h1
`define JTID_ID_W 32
`define JTID_ID_VALUE 32'h0a5a5001
`define JTID_TCK_HALF 4'h4
`define JTID_FIFO_DEPTH 8
`define JTID_FIFO_AW 3
`define JTID_DR_W 32
`endif

// >>> jtid_pkg.sv
// Types for the two ends of the scan link; each type serves one end only
`default_nettype none
package jtid_pkg;
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} jtid_tap_t;
	typedef enum logic [2:0] {
		H_IDLE, H_LOW, H_HIGH, H_NEXT
	} jtid_hst_t;
	// One host command: run a tms/tdi pair list of n bits
	typedef struct packed {
		logic [31:0] tms;
		logic [31:0] tdi;
		logic [5:0] len;
	} jtid_cmd_t;
endpackage
`default_nettype wire

// >>> jtid_if.sv
// Scan link wires between controller and device
`timescale 1ns/1ps
`default_nettype none
interface jtid_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	modport ctrl (output tck, output tms, output tdi, input tdo);
	modport dev (input tck, input tms, input tdi, output tdo);
endinterface
`default_nettype wire

// >>> jtid_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module jtid_fifo #(
	parameter int W = 32,
	parameter int D = 8,
	parameter int AW = 3
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	logic [W-1:0] mem [D];
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} jtid_fst_t;
	jtid_fst_t s_r, s_nxt;
	logic push, pop;

	// Count-based full/empty keeps depth exact
	assign o_in_ready = s_r.cnt < (AW+1)'(D);
	assign o_out_valid = s_r.cnt != '0;
	assign o_out_data = mem[s_r.rp];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_comb begin
		s_nxt = s_r;
		if (push) s_nxt.wp = s_r.wp + 1'b1;
		if (pop) s_nxt.rp = s_r.rp + 1'b1;
		s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) s_r <= '0;
		else s_r <= s_nxt;
		if (push) mem[s_r.wp] <= i_in_data;
	end
endmodule
`default_nettype wire

// >>> jtid_dev.sv
// Device end: scan test port with the identification shift defect
`timescale 1ns/1ps
`default_nettype none
`include "jtid_defines.svh"
module jtid_dev (
	input wire logic i_clk,
	input wire logic i_rst,
	jtid_if.dev lnk,
	output logic [`JTID_IR_W-1:0] o_ir,
	output logic o_in_reset,
	output logic [`JTID_DR_W-1:0] o_user_dr,
	output logic o_user_upd
);
	typedef struct packed {
		logic [1:0] tck_s;
		logic [1:0] tms_s;
		logic [1:0] tdi_s;
		logic tck_d;
		jtid_pkg::jtid_tap_t st;
		logic [`JTID_IR_W-1:0] ir;
		logic [`JTID_IR_W-1:0] ir_sh;
		logic [`JTID_ID_W-1:0] id_sh;
		logic byp;
		logic [`JTID_DR_W-1:0] usr_sh;
		logic [`JTID_DR_W-1:0] usr;
		logic upd;
		logic tdo;
		logic in_rst;
	} jtid_dst_t;
	jtid_dst_t s_r, s_nxt;
	logic rise, fall, tms, tdi;

	// Two flops before use; second stage feeds the edge detector
	assign tms = s_r.tms_s[1];
	assign tdi = s_r.tdi_s[1];
	assign rise = s_r.tck_s[1] && !s_r.tck_d;
	assign fall = !s_r.tck_s[1] && s_r.tck_d;

	function automatic jtid_pkg::jtid_tap_t nxt_state(jtid_pkg::jtid_tap_t c, logic m);
		case (c)
			jtid_pkg::TLR: nxt_state = m ? jtid_pkg::TLR : jtid_pkg::RTI;
			jtid_pkg::RTI: nxt_state = m ? jtid_pkg::SEL_DR : jtid_pkg::RTI;
			jtid_pkg::SEL_DR: nxt_state = m ? jtid_pkg::SEL_IR : jtid_pkg::CAP_DR;
			jtid_pkg::CAP_DR: nxt_state = m ? jtid_pkg::EX1_DR : jtid_pkg::SH_DR;
			jtid_pkg::SH_DR: nxt_state = m ? jtid_pkg::EX1_DR : jtid_pkg::SH_DR;
			jtid_pkg::EX1_DR: nxt_state = m ? jtid_pkg::UPD_DR : jtid_pkg::PA_DR;
			jtid_pkg::PA_DR: nxt_state = m ? jtid_pkg::EX2_DR : jtid_pkg::PA_DR;
			jtid_pkg::EX2_DR: nxt_state = m ? jtid_pkg::UPD_DR : jtid_pkg::SH_DR;
			jtid_pkg::UPD_DR: nxt_state = m ? jtid_pkg::SEL_DR : jtid_pkg::RTI;
			jtid_pkg::SEL_IR: nxt_state = m ? jtid_pkg::TLR : jtid_pkg::CAP_IR;
			jtid_pkg::CAP_IR: nxt_state = m ? jtid_pkg::EX1_IR : jtid_pkg::SH_IR;
			jtid_pkg::SH_IR: nxt_state = m ? jtid_pkg::EX1_IR : jtid_pkg::SH_IR;
			jtid_pkg::EX1_IR: nxt_state = m ? jtid_pkg::UPD_IR : jtid_pkg::PA_IR;
			jtid_pkg::PA_IR: nxt_state = m ? jtid_pkg::EX2_IR : jtid_pkg::PA_IR;
			jtid_pkg::EX2_IR: nxt_state = m ? jtid_pkg::UPD_IR : jtid_pkg::SH_IR;
			jtid_pkg::UPD_IR: nxt_state = m ? jtid_pkg::SEL_DR : jtid_pkg::RTI;
			default: nxt_state = jtid_pkg::TLR;
		endcase
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.tck_s = {s_r.tck_s[0], lnk.tck};
		s_nxt.tms_s = {s_r.tms_s[0], lnk.tms};
		s_nxt.tdi_s = {s_r.tdi_s[0], lnk.tdi};
		s_nxt.tck_d = s_r.tck_s[1];
		s_nxt.upd = 1'b0;
		// Actions on rising test clock, state as it stands before the step
		if (rise) begin
			s_nxt.st = nxt_state(s_r.st, tms);
			case (s_r.st)
				jtid_pkg::TLR: s_nxt.ir = `JTID_IR_IDCODE;
				jtid_pkg::CAP_IR: s_nxt.ir_sh = `JTID_IR_CAPTURE;
				jtid_pkg::SH_IR: s_nxt.ir_sh = {tdi, s_r.ir_sh[`JTID_IR_W-1:1]};
				jtid_pkg::UPD_IR: s_nxt.ir = s_r.ir_sh;
				jtid_pkg::CAP_DR: begin
					s_nxt.id_sh = `JTID_ID_VALUE;
					s_nxt.byp = 1'b0;
					s_nxt.usr_sh = s_r.usr;
				end
				jtid_pkg::SH_DR: begin
					// Defect kept on purpose: ones enter, not the serial input
					s_nxt.id_sh = {1'b1, s_r.id_sh[`JTID_ID_W-1:1]};
					s_nxt.byp = tdi;
					s_nxt.usr_sh = {tdi, s_r.usr_sh[`JTID_DR_W-1:1]};
				end
				jtid_pkg::UPD_DR: begin
					// Identification word is read-only; nothing applied
					if (s_r.ir != `JTID_IR_IDCODE && s_r.ir != `JTID_IR_BYPASS) begin
						s_nxt.usr = s_r.usr_sh;
						s_nxt.upd = 1'b1;
					end
				end
				default: ;
			endcase
			// Default instruction takes effect on arrival, not one clock later
			if (s_nxt.st == jtid_pkg::TLR) s_nxt.ir = `JTID_IR_IDCODE;
		end
		// Output changes on the falling test clock
		if (fall) begin
			if (s_r.st == jtid_pkg::SH_IR) s_nxt.tdo = s_r.ir_sh[0];
			else if (s_r.st == jtid_pkg::SH_DR) begin
				if (s_r.ir == `JTID_IR_IDCODE) s_nxt.tdo = s_r.id_sh[0];
				else if (s_r.ir == `JTID_IR_BYPASS) s_nxt.tdo = s_r.byp;
				else s_nxt.tdo = s_r.usr_sh[0];
			end
		end
		// Registered so the reset-state output comes from a flop
		s_nxt.in_rst = s_nxt.st == jtid_pkg::TLR;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_r <= '0;
			s_r.st <= jtid_pkg::TLR;
			s_r.in_rst <= 1'b1;
			s_r.ir <= `JTID_IR_IDCODE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.tdo = s_r.tdo;
	assign o_ir = s_r.ir;
	assign o_in_reset = s_r.in_rst;
	assign o_user_dr = s_r.usr;
	assign o_user_upd = s_r.upd;
endmodule
`default_nettype wire

// >>> jtid_ctrl.sv
// Controller end: drives test clock and bit sequences, buffers results
`timescale 1ns/1ps
`default_nettype none
`include "jtid_defines.svh"
module jtid_ctrl (
	input wire logic i_clk,
	input wire logic i_rst,
	jtid_if.ctrl lnk,
	input wire logic i_cmd_valid,
	output logic o_cmd_ready,
	input wire logic [31:0] i_cmd_tms,
	input wire logic [31:0] i_cmd_tdi,
	input wire logic [5:0] i_cmd_len,
	output logic o_res_valid,
	input wire logic i_res_ready,
	output logic [31:0] o_res_data
);
	typedef struct packed {
		jtid_pkg::jtid_hst_t st;
		jtid_pkg::jtid_cmd_t cmd;
		logic [5:0] idx;
		logic [3:0] div;
		logic [31:0] cap;
		logic [1:0] tdo_s;
		logic tck;
		logic tms;
		logic tdi;
		logic push;
		logic rdy;
	} jtid_cst_t;
	jtid_cst_t s_r, s_nxt;
	logic f_ready;

	// Sequences keeping are the user's; this end just plays them
	always_comb begin
		s_nxt = s_r;
		s_nxt.tdo_s = {s_r.tdo_s[0], lnk.tdo};
		s_nxt.push = 1'b0;
		s_nxt.div = s_r.div + 4'h1;
		case (s_r.st)
			jtid_pkg::H_IDLE: begin
				s_nxt.div = 4'h0;
				if (i_cmd_valid && i_cmd_len != 6'h00 && !s_r.push) begin
					s_nxt.cmd = '{tms: i_cmd_tms, tdi: i_cmd_tdi, len: i_cmd_len};
					s_nxt.idx = 6'h00;
					s_nxt.cap = 32'h0;
					s_nxt.st = jtid_pkg::H_LOW;
					s_nxt.tms = i_cmd_tms[0];
					s_nxt.tdi = i_cmd_tdi[0];
				end
			end
			jtid_pkg::H_LOW: if (s_r.div == `JTID_TCK_HALF) begin
				// Rising test clock; the device shifts on it
				s_nxt.div = 4'h0;
				s_nxt.tck = 1'b1;
				s_nxt.st = jtid_pkg::H_HIGH;
			end
			jtid_pkg::H_HIGH: if (s_r.div == `JTID_TCK_HALF) begin
				// Sample late: device output trails a fall by five clocks through
				// both synchronisers, too slow for the low phase, and holds till next fall
				s_nxt.cap[s_r.idx[4:0]] = s_r.tdo_s[1];
				s_nxt.div = 4'h0;
				s_nxt.tck = 1'b0;
				s_nxt.idx = s_r.idx + 6'h01;
				s_nxt.st = (s_r.idx + 6'h01 == s_r.cmd.len) ? jtid_pkg::H_NEXT : jtid_pkg::H_LOW;
				s_nxt.tms = s_r.cmd.tms[5'(s_r.idx + 6'h01)];
				s_nxt.tdi = s_r.cmd.tdi[5'(s_r.idx + 6'h01)];
			end
			jtid_pkg::H_NEXT: if (f_ready) begin
				// Stall here while the result FIFO is full
				s_nxt.push = 1'b1;
				s_nxt.st = jtid_pkg::H_IDLE;
			end
			default: s_nxt.st = jtid_pkg::H_IDLE;
		endcase
		// Ready kept in a flop so the output is glitch free
		s_nxt.rdy = (s_nxt.st == jtid_pkg::H_IDLE) && !s_nxt.push;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_r <= '0;
			s_r.st <= jtid_pkg::H_IDLE;
			s_r.tms <= 1'b1;
			s_r.rdy <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	jtid_fifo #(.W(32), .D(`JTID_FIFO_DEPTH), .AW(`JTID_FIFO_AW)) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_in_valid(s_r.push),
		.o_in_ready(f_ready),
		.i_in_data(s_r.cap),
		.o_out_valid(o_res_valid),
		.i_out_ready(i_res_ready),
		.o_out_data(o_res_data)
	);

	assign o_cmd_ready = s_r.rdy;
	assign lnk.tck = s_r.tck;
	assign lnk.tms = s_r.tms;
	assign lnk.tdi = s_r.tdi;
endmodule
`default_nettype wire

// >>> jtid_props.sv
// Wire-level checks on the scan link between controller and device
`timescale 1ns/1ps
`default_nettype none
module jtid_props (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// Test clock high phase is five system clocks and the low phase at least five, so the device's synchroniser keeps up
	a_tck_high_span: assert property ($rose(tck) |-> tck [*5] ##1 !tck)
		else $error("test clock high phase has the wrong length");
	a_tck_low_span: assert property ($fell(tck) |-> !tck [*5])
		else $error("test clock low phase too short");
	a_tck_rise_gap: assert property ($rose(tck) |-> !$past(tck, 5))
		else $error("test clock rose too soon after falling");
	// Lines move only in the low phase, never near the sampling edge
	a_tms_low_change: assert property ($changed(tms) |-> !tck)
		else $error("mode line moved while test clock high");
	a_tdi_low_change: assert property ($changed(tdi) |-> !tck)
		else $error("data line moved while test clock high");
	a_tdo_low_change: assert property ($changed(tdo) |-> !tck)
		else $error("device output moved while test clock high");
	a_line_setup_hold: assert property ($rose(tck) |-> tms == $past(tms, 4) && tdi == $past(tdi, 4))
		else $error("lines not settled before test clock rise");
	a_idle_after_reset: assert property ($fell(i_rst) |-> tms && !tck && !tdi && !tdo)
		else $error("link not idle after reset");
endmodule
`default_nettype wire

// >>> jtid_test.sv
// Self-checking bench: controller and device joined over the scan link
`timescale 1ns/1ps
`default_nettype none
`include "jtid_defines.svh"
module jtid_test;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic [31:0] cmd_tms = 32'h0;
	logic [31:0] cmd_tdi = 32'h0;
	logic [5:0] cmd_len = 6'h0;
	logic res_ready = 1'b0;
	logic cmd_ready, res_valid, upd, in_reset;
	logic [31:0] res_data, r, user_dr;
	logic [`JTID_IR_W-1:0] ir;
	int fail_count = 0;
	int total_checks = 0;
	int upd_count = 0;
	jtid_if lnk ();
	jtid_ctrl u_jtid_ctrl (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk), .i_cmd_valid(cmd_valid),
		.o_cmd_ready(cmd_ready), .i_cmd_tms(cmd_tms), .i_cmd_tdi(cmd_tdi), .i_cmd_len(cmd_len),
		.o_res_valid(res_valid), .i_res_ready(res_ready), .o_res_data(res_data));
	jtid_dev u_jtid_dev (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk), .o_ir(ir),
		.o_in_reset(in_reset), .o_user_dr(user_dr), .o_user_upd(upd));
	jtid_props u_jtid_props (.i_clk(i_clk), .i_rst(i_rst), .tck(lnk.tck), .tms(lnk.tms),
		.tdi(lnk.tdi), .tdo(lnk.tdo));
	always #5 i_clk = ~i_clk;
	// Count user-register update pulses
	always @(posedge i_clk) begin
		if (upd === 1'b1) upd_count++;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask
	// Ready is sampled at the falling edge, so the taking edge is never raced
	task automatic send(input logic [31:0] tms, input logic [31:0] tdi, input logic [5:0] len);
		int n;
		n = 0;
		@(posedge i_clk);
		cmd_valid <= 1'b1;
		cmd_tms <= tms;
		cmd_tdi <= tdi;
		cmd_len <= len;
		do begin @(negedge i_clk); n++; end while (cmd_ready !== 1'b1 && n < 3000);
		@(posedge i_clk);
		cmd_valid <= 1'b0;
		if (n >= 3000) chk("command taken", 32'h1, 32'h0);
	endtask
	task automatic take(output logic [31:0] res);
		int n;
		n = 0;
		@(posedge i_clk);
		res_ready <= 1'b1;
		do begin @(negedge i_clk); n++; end while (res_valid !== 1'b1 && n < 3000);
		res = res_data;
		@(posedge i_clk);
		res_ready <= 1'b0;
		if (n >= 3000) chk("result ready", 32'h1, 32'h0);
	endtask
	task automatic scan(input logic [31:0] tms, input logic [31:0] tdi, input logic [5:0] len);
		send(tms, tdi, len);
		take(r);
	endtask
	task automatic t_reset();
		chk("reset instruction", `JTID_IR_IDCODE, ir);
		chk("reset state", 32'h1, in_reset);
	endtask
	// Identification scan: value, then forced ones despite zero input
	task automatic t_idcode();
		scan(32'h2, 32'h0, 6'h4);
		scan(32'h0, 32'h0, 6'h20);
		chk("id value", `JTID_ID_VALUE, r);
		scan(32'h0, 32'h0, 6'h20);
		chk("id fill", 32'hffffffff, r);
		scan(32'h3, 32'h0, 6'h3);
		chk("update pulses", 32'h0, upd_count);
		scan(32'h1, 32'h0, 6'h3);
		scan(32'h0, 32'h5a5a5a5a, 6'h20);
		chk("id kept", `JTID_ID_VALUE, r);
		scan(32'h3, 32'h0, 6'h3);
	endtask
	// Load the bypass code, shift through one stage, then return to reset
	task automatic t_bypass();
		scan(32'h183, 32'hf0, 6'ha);
		chk("bypass instruction", `JTID_IR_BYPASS, ir);
		scan(32'h1, 32'h0, 6'h3);
		scan(32'h0, 32'hb4, 6'h8);
		chk("bypass data", 32'h68, {24'h0, r[7:0]});
		scan(32'h1f, 32'h0, 6'h5);
		chk("back to id", `JTID_IR_IDCODE, ir);
		chk("back in reset", 32'h1, in_reset);
	endtask
	// User code 2 from reset: shift a word in, update, read it back
	task automatic t_user();
		scan(32'h306, 32'h40, 6'hb);
		chk("user instruction", 32'h2, ir);
		scan(32'h1, 32'h0, 6'h3);
		scan(32'h80000000, 32'hc3a55a3c, 6'h20);
		chk("user old value", 32'h0, r);
		scan(32'h1, 32'h0, 6'h2);
		chk("user update", 32'hc3a55a3c, user_dr);
		chk("user pulses", 32'h1, upd_count);
		scan(32'h1, 32'h0, 6'h3);
		scan(32'h80000000, 32'h0, 6'h20);
		chk("user readback", 32'hc3a55a3c, r);
		scan(32'h1f, 32'h0, 6'h5);
		chk("user to reset", `JTID_IR_IDCODE, ir);
	endtask
	// Fill the result buffer while nobody drains it, then empty it
	task automatic t_fifo();
		for (int i = 0; i < 9; i++) send(32'h1, 32'h0, 6'h1);
		repeat (100) @(negedge i_clk);
		chk("stalled when full", 32'h0, cmd_ready);
		for (int i = 0; i < 9; i++) take(r);
		repeat (40) @(negedge i_clk);
		chk("drained", 32'h0, res_valid);
		chk("reset held", `JTID_IR_IDCODE, ir);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_reset();
		t_idcode();
		t_bypass();
		t_user();
		t_fifo();
		test_done();
	end
	// Whole run needs a few thousand cycles; this cuts a hang short
	initial begin
		repeat (30000) @(posedge i_clk);
		fail_count++;
		test_done();
	end
endmodule
`default_nettype wire
